// *** verilog/sdi_pkg.sv ***
// Package of constants and types for the serial converter input port.
package sdi_pkg;
    // Frame geometry.
    localparam int FRAME_BITS     = 24;                 // Bits in one write frame.
    localparam int DATA_BITS      = 16;                 // Converter code width.
    localparam int MODE_HIGH_POS  = 17;                 // Position of mode_bit_high in the frame.
    localparam int MODE_LOW_POS   = 16;                 // Position of mode_bit_low in the frame.
    localparam int COUNT_WIDTH    = 5;                  // Width of the bit counter.
    // Values after reset.
    localparam logic [15:0] CODE_RESET = 16'h0000;      // Zero scale until a valid write.
    localparam logic [1:0]  MODE_RESET = 2'h0;          // Normal operation after reset.
    localparam logic [15:0] CODE_ZERO  = 16'h0000;      // Zero-scale code.
    localparam logic [15:0] CODE_FULL  = 16'hFFFF;      // Full-scale code.
    // Host timing limits; the bench host model paces frames with its own fixed cycle counts.
    localparam int CLOCK_PERIOD_NS   = 8;               // System clock period.
    localparam int SELECT_HIGH_NS    = 33;              // Least idle time of frame select between frames.
    localparam int SELECT_HIGH_CYC   = (SELECT_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LINK_MAX_MHZ      = 30;              // Fastest serial clock the host may use.
    // Buffer sizing.
    localparam int FIFO_DEPTH = 8;                      // Words held between link and converter.
    localparam int WORD_BITS  = 18;                     // Mode plus code per buffered word.
    // Operating modes decoded from the two mode bits.
    typedef enum logic [1:0] {
        SDI_MODE_NORMAL    = 2'h0,
        SDI_MODE_PD_1K     = 2'h1,
        SDI_MODE_PD_100K   = 2'h2,
        SDI_MODE_PD_TRISTATE = 2'h3
    } sdi_mode_type;
endpackage : sdi_pkg

// *** verilog/sdi_fifo.sv ***
// Small synchronous FIFO in flip-flops with valid and ready on both sides.
`timescale 1ns/10ps
module sdi_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];   // Word storage.
    logic [AW-1:0]    writePtr;        // Next slot to fill.
    logic [AW-1:0]    readPtr;         // Oldest slot.
    logic [AW:0]      fill;            // Words held.

    wire doPush = inValid && inReady;  // A word enters.
    wire doPop  = outValid && outReady; // A word leaves.

    assign inReady  = (fill != (AW+1)'(DEPTH));
    assign outValid = (fill != '0);
    assign outData  = store[readPtr];

    // Pointers and count; push and pop may happen in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            writePtr <= '0;
            readPtr  <= '0;
            fill     <= '0;
        end else begin
            if (doPush) begin
                writePtr <= (writePtr == AW'(DEPTH - 1)) ? '0 : writePtr + 1'b1;
            end
            if (doPop) begin
                readPtr <= (readPtr == AW'(DEPTH - 1)) ? '0 : readPtr + 1'b1;
            end
            fill <= fill + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // Storage has no reset; only filled slots are ever read.
    always_ff @(posedge clock) begin
        if (doPush) begin
            store[writePtr] <= inData;
        end
    end
endmodule : sdi_fifo

// *** verilog/sdi_serial_port.sv ***
// Serial write-only input port: frame capture, abort, mode and code update.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Shift only while frame select is low.
// - Sample data on falling serial clock edges.
// - Shift register holds twenty-four bits.
// - Update code after twenty-fourth edge.
// - Early select rise aborts; nothing changes.
// - Code is straight binary, zero to full.
// - MSB first: six ignored, two mode, sixteen data.
// - Mode bits: normal, 1k, 100k, three-state.
// - Code kept unchanged during power-down; power-down frames here still load it.
module sdi_serial_port
    import sdi_pkg::*;
#(
    parameter int FIFO_DEPTH_P = sdi_pkg::FIFO_DEPTH
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 frameSelectN,
    input  wire logic                 serialClock,
    input  wire logic                 serialData,
    output logic [15:0]               converterCode,
    output sdi_pkg::sdi_mode_type     operatingMode,
    output logic                      powerDown,
    output logic                      updateStrobe,
    output logic                      frameAborted
);
    import sdi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. The link clock is only a sampled input here, so the
    // 30 MHz ceiling keeps each serial level at least two system cycles wide.

    logic [1:0] selSync;               // Frame select, two stages.
    logic [1:0] sclkSync;              // Serial clock, two stages.
    logic [1:0] dinSync;               // Serial data, two stages.
    logic       selPrev;               // Previous synchronised select.
    logic       sclkPrev;              // Previous synchronised serial clock.

    // Two flops per pin before any logic reads it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            selSync  <= 2'b11;
            sclkSync <= 2'b11;                          // Idle level of the serial clock, so no false edge.
            dinSync  <= 2'b00;
        end else begin
            selSync  <= {selSync[0], frameSelectN};
            sclkSync <= {sclkSync[0], serialClock};
            dinSync  <= {dinSync[0], serialData};
        end
    end

    // History for edge detection, fed only from the second stage.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            selPrev  <= 1'b1;
            sclkPrev <= 1'b1;                           // Matches the synchroniser's reset level.
        end else begin
            selPrev  <= selSync[1];
            sclkPrev <= sclkSync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge decode and frame state.

    wire selLow     = !selSync[1];                       // Frame active level.
    wire selRise    = selSync[1] && !selPrev;            // Select went high.
    wire sclkFall   = sclkPrev && !sclkSync[1];          // Falling serial clock edge.

    // States of the frame tracker.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } sdi_frame_type;

    sdi_frame_type          state;                        // Current frame state.
    sdi_frame_type          next_state;                   // Next frame state.
    logic [FRAME_BITS-1:0]  shiftReg;                     // Input shift register.
    logic [COUNT_WIDTH-1:0] bitCount;                     // Falling edges seen this frame.

    wire lastEdge   = sclkFall && (bitCount == COUNT_WIDTH'(FRAME_BITS - 1));
    wire doShift    = selLow && sclkFall && (state == ST_SHIFT);
    wire frameDone  = doShift && lastEdge;
    wire abortSeen  = selRise && (state == ST_SHIFT);

    // Completed word, MSB first; top six bits are ignored.
    wire [FRAME_BITS-1:0]   fullWord  = {shiftReg[FRAME_BITS-2:0], dinSync[1]};
    wire [1:0]              wordMode  = {fullWord[MODE_HIGH_POS], fullWord[MODE_LOW_POS]};
    wire [DATA_BITS-1:0]    wordCode  = fullWord[DATA_BITS-1:0];

    // Next-state decode. A frame starts when select is seen low from idle; any
    // time select is high the tracker returns to idle.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (selLow) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!selLow) begin
                    next_state = ST_IDLE;
                end else if (frameDone) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // Extra edges after the 24th are ignored until select rises.
                if (!selLow) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shift register and counter; both cleared whenever select is high.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shiftReg <= '0;
            bitCount <= '0;
        end else if (!selLow) begin
            shiftReg <= '0;
            bitCount <= '0;
        end else if (doShift) begin
            shiftReg <= fullWord;
            bitCount <= bitCount + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer between the frame decoder and the converter register. It decouples
    // capture from apply; the apply side drains one word a cycle, so it never
    // stalls in practice, but a full buffer would drop the word, which a 24-edge
    // frame cannot cause.

    logic                 pushReady;                      // Buffer has room.
    logic [WORD_BITS-1:0] popWord;                        // Oldest captured word.
    logic                 popValid;                       // A captured word waits.

    sdi_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clock    (clock),
        .nrst     (nrst),
        .inData   ({wordMode, wordCode}),
        .inValid  (frameDone && pushReady),
        .inReady  (pushReady),
        .outData  (popWord),
        .outValid (popValid),
        .outReady (1'b1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Converter register and mode. Only whole frames reach here, so an abort
    // leaves both untouched. The code is stored even in power-down and is kept
    // across it; power-down only gates the analogue stage.

    wire [1:0]           applyMode = popWord[WORD_BITS-1:DATA_BITS];
    wire [DATA_BITS-1:0] applyCode = popWord[DATA_BITS-1:0];

    // Apply the oldest buffered word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            converterCode <= CODE_RESET;
            operatingMode <= sdi_mode_type'(MODE_RESET);
            powerDown     <= 1'b0;
        end else if (popValid) begin
            converterCode <= applyCode;
            operatingMode <= sdi_mode_type'(applyMode);
            powerDown     <= (applyMode != 2'h0);
        end
    end

    // One-cycle strobes: update applied, frame aborted.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            updateStrobe <= 1'b0;
            frameAborted <= 1'b0;
        end else begin
            updateStrobe <= popValid;
            frameAborted <= abortSeen;
        end
    end
endmodule : sdi_serial_port

// *** verif/sdi_serial_port_checker.sv ***
// Concurrent checks on the serial port outputs and their timing.
`timescale 1ns/10ps
module sdi_serial_port_checker (
    input wire logic                  clock,
    input wire logic                  nrst,
    input wire logic                  frameSelectN,
    input wire logic                  serialClock,
    input wire logic                  serialData,
    input wire logic [15:0]           converterCode,
    input wire sdi_pkg::sdi_mode_type operatingMode,
    input wire logic                  powerDown,
    input wire logic                  updateStrobe,
    input wire logic                  frameAborted
);
    import sdi_pkg::*;
    // All checks share the system clock and are off during reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    AST_STROBE_ONE_CYCLE: assert property (updateStrobe |=> !updateStrobe)
        else $error("Update strobe wider than one cycle.");
    AST_ABORT_ONE_CYCLE: assert property (frameAborted |=> !frameAborted)
        else $error("Abort pulse wider than one cycle.");
    // A new code is announced by the strobe in the same cycle in which it lands.
    AST_CODE_CHANGE_STROBED: assert property ($changed(converterCode) |-> updateStrobe)
        else $error("Code changed without an update strobe.");
    AST_MODE_CHANGE_STROBED: assert property ($changed(operatingMode) |-> updateStrobe)
        else $error("Mode changed without an update strobe.");
    AST_POWER_DOWN_FLAG: assert property (updateStrobe |-> powerDown == (operatingMode != SDI_MODE_NORMAL))
        else $error("Power-down flag disagrees with the mode.");
    // An aborted frame must leave code and mode alone for the following cycles.
    AST_ABORT_KEEPS_STATE: assert property (frameAborted |=> ($stable(converterCode) && $stable(operatingMode)) [*3])
        else $error("Aborted frame changed code or mode.");
    // Long idle select means no frame can be completing any more.
    AST_IDLE_NO_UPDATE: assert property (frameSelectN [*8] |=> !updateStrobe)
        else $error("Update while frame select idle.");
    AST_ABORT_AFTER_RISE: assert property (frameAborted |-> frameSelectN)
        else $error("Abort reported while select is low.");
endmodule : sdi_serial_port_checker
bind sdi_serial_port sdi_serial_port_checker i_chk (.clock(clock), .nrst(nrst), .frameSelectN(frameSelectN),
    .serialClock(serialClock), .serialData(serialData), .converterCode(converterCode),
    .operatingMode(operatingMode), .powerDown(powerDown), .updateStrobe(updateStrobe), .frameAborted(frameAborted));

// *** verif/sdi_host_model.sv ***
// Host master model that sends write frames on the three serial wires.
`timescale 1ns/10ps
module sdi_host_model (
    input wire logic clock,
    output logic     frameSelectN,
    output logic     serialClock,
    output logic     serialData
);
    // Idle: select high, serial clock high so that only in-frame falls exist.
    initial begin
        frameSelectN = 1'b1;
        serialClock  = 1'b1;
        serialData   = 1'b0;
    end
    // Sends nFalls bits MSB first; fewer than 24 makes an abort, bits past 24 are spares.
    task automatic sendFrame(input logic [23:0] frame, input int nFalls);
        @(posedge clock) frameSelectN <= 1'b0;
        for (int i = 0; i < nFalls; i++) begin
            // Low lasts 5 cycles and high 6, an 88 ns period, well below the top rate.
            @(posedge clock) serialData <= (i < 24) ? frame[23 - i] : ~frame[0];
            repeat (5) @(posedge clock);
            serialClock <= 1'b0;
            repeat (5) @(posedge clock);
            serialClock <= 1'b1;
        end
        // Released data shows the inverse so a stale bit is never mistaken for a held one.
        @(posedge clock) frameSelectN <= 1'b1;
        serialData <= ~serialData;
        repeat (8) @(posedge clock);
    endtask : sendFrame
endmodule : sdi_host_model

// *** verif/test_sdi_serial_port.sv ***
// Self-checking bench: random frames, aborts and spare clocks against a reference model.
`timescale 1ns/10ps
module test_sdi_serial_port;
    import sdi_pkg::*;
    logic         clock;       // System clock.
    logic         nrst;        // Active-low reset.
    logic         frameSelectN, serialClock, serialData;
    logic  [15:0] converterCode;
    sdi_mode_type operatingMode;
    logic         powerDown, updateStrobe, frameAborted;
    int           failures, checks, strobes, aborts, expStrobes, expAborts;
    logic  [31:0] seed;        // Xorshift state.
    logic  [15:0] expCode, code;
    logic  [1:0]  expMode, mode;
    int           nFalls;
    sdi_host_model i_host (.clock(clock), .frameSelectN(frameSelectN), .serialClock(serialClock),
        .serialData(serialData));
    sdi_serial_port i_dut (.clock(clock), .nrst(nrst), .frameSelectN(frameSelectN), .serialClock(serialClock),
        .serialData(serialData), .converterCode(converterCode), .operatingMode(operatingMode),
        .powerDown(powerDown), .updateStrobe(updateStrobe), .frameAborted(frameAborted));
    always #4 clock = ~clock;
    // Pulses are counted at the falling edge where outputs have settled.
    always @(negedge clock) begin
        if (updateStrobe === 1'b1) strobes++;
        if (frameAborted === 1'b1) aborts++;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift
    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : report
    task automatic cmpCode(input logic [15:0] got, input logic [15:0] exp); report(got, exp); endtask : cmpCode
    task automatic cmpMode(input logic [1:0] got, input logic [1:0] exp); report({14'h0000, got}, {14'h0000, exp}); endtask : cmpMode
    task automatic cmpFlag(input logic got, input logic exp); report({15'h0000, got}, {15'h0000, exp}); endtask : cmpFlag
    task automatic conclude();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // Watchdog: a hung run counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        {failures, checks, strobes, aborts, expStrobes, expAborts} = '0;
        seed = 32'h7186;
        expCode = CODE_RESET;
        expMode = MODE_RESET;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(negedge clock);
        cmpCode(converterCode, CODE_RESET);
        cmpMode(operatingMode, MODE_RESET);
        cmpFlag(powerDown, 1'b0);
        // Frames: end codes first, every mode, a 23-bit and a 1-bit abort, and spare falls.
        for (int i = 0; i < 14; i++) begin
            seed = xorshift(seed);
            mode = (i < 2 || i == 6) ? 2'h0 : 2'(i % 4);
            code = (i == 0) ? CODE_ZERO : (i == 1) ? CODE_FULL : seed[15:0];
            if (mode != 2'h0) code = expCode;
            nFalls = (i == 5) ? 23 : (i == 9) ? 1 : (i == 7) ? 26 : 24;
            i_host.sendFrame({seed[31:26], mode, code}, nFalls);
            if (nFalls >= 24) begin
                expCode = code;
                expMode = mode;
                expStrobes++;
            end else expAborts++;
            @(negedge clock);
            cmpCode(converterCode, expCode);
            cmpMode(operatingMode, expMode);
            cmpFlag(powerDown, expMode != 2'h0);
            cmpCode(16'(strobes), 16'(expStrobes));
            cmpCode(16'(aborts), 16'(expAborts));
        end
        conclude();
    end
endmodule : test_sdi_serial_port
